// ===== src/vfrs_regs.svh
/*
 * Constants of the virtual FIFO ring switch: node counts, slot limits,
 * widths, burst size and timing figures.
 * Assumes inclusion by name from the package and the design modules.
 */
`ifndef VFRS_REGS_SVH
`define VFRS_REGS_SVH

`define VFRS_NODES          6
`define VFRS_MAX_SLOTS      6
`define VFRS_WORD_W         32
`define VFRS_HALF_W         16
`define VFRS_BLOCK_WORDS    64
`define VFRS_FIFO_DEPTH     128
`define VFRS_SLOT_MBPS_X10  666
`define VFRS_FRAME_SLOTS    6
`define VFRS_LINK_MIN_MHZ   60
`define VFRS_LINK_MAX_MHZ   100

`endif

// ===== src/vfrs_pkg.sv
/*
 * Types shared by the ring switch modules.
 * Assumes vfrs_regs.svh is on the include path.
 */
`include "vfrs_regs.svh"
package vfrs_pkg;
    typedef logic [`VFRS_WORD_W-1:0] vfrs_word_t;
    typedef logic [2:0]              vfrs_node_t;
    typedef logic [`VFRS_NODES-1:0]  vfrs_nmask_t;
    typedef enum logic [1:0] {VFRS_PH_IDLE, VFRS_PH_CONFIG, VFRS_PH_RUN} vfrs_phase_t;
endpackage

// ===== src/vfrs_fifo.sv
/*
 * Synchronous word FIFO used at either end of a connection.
 * Assumes one clock, a clock enable and a synchronous active high reset.
 */
`timescale 1ns/10ps
`include "vfrs_regs.svh"
module vfrs_fifo
    import vfrs_pkg::*;
#(
    parameter int WIDTH = `VFRS_WORD_W,
    parameter int DEPTH = `VFRS_FIFO_DEPTH,
    parameter int BLOCK = `VFRS_BLOCK_WORDS
)(
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    input  wire logic             i_ce,
    input  wire logic             i_flush,
    input  wire logic             i_wr,
    input  wire logic [WIDTH-1:0] i_wdata,
    input  wire logic             i_rd,
    output logic      [WIDTH-1:0] o_rdata,
    output logic                  o_full,
    output logic                  o_empty,
    output logic                  o_blk_wr,
    output logic                  o_blk_rd
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < BLOCK || (1 << AW) != DEPTH)
    begin : g_bad_depth
        $error("vfrs_fifo: DEPTH must be a power of two not below BLOCK");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp;
    logic [AW-1:0]    rp;
    logic [AW:0]      cnt;
    wire              do_wr = i_wr && !o_full;
    wire              do_rd = i_rd && !o_empty;
    wire [AW:0]       next_cnt = cnt + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};

    assign o_rdata  = mem[rp];
    assign o_full   = cnt == (AW+1)'(DEPTH);
    assign o_empty  = cnt == '0;
    assign o_blk_wr = cnt <= (AW+1)'(DEPTH - BLOCK);
    assign o_blk_rd = cnt >= (AW+1)'(BLOCK);

    always_ff @(posedge i_mclk)
    begin
        if (do_wr && i_ce)
            mem[wp] <= i_wdata;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst || (i_ce && i_flush))
        begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end
        else if (i_ce)
        begin
            wp  <= wp + AW'(do_wr);
            rp  <= rp + AW'(do_rd);
            cnt <= next_cnt;
        end
    end
endmodule

// ===== src/vfrs_switch.sv
/*
 * Ring switch for one board: six nodes, each with one output FIFO facing the
 * socket and one input FIFO facing the socket. A ring of six time slots moves
 * words from source output FIFOs into destination input FIFOs.
 * Assumes socket pins and the socket FIFO clock come from outside this clock
 * domain; connections are written only while the run phase is off.
 */
`timescale 1ns/10ps
`include "vfrs_regs.svh"
// Function
// - 32-bit socket words, 16-bit mode when detected
// - Socket clock 60-100 MHz, one word each
// - Connection joins output FIFO to input FIFO
// - One to six ring slots per connection
// - Six nodes per board, boards chainable
// - Connection built from two real FIFOs
// - Configure first, then run as FIFO
// - Ends may use different FIFO numbers
// - One source may feed several destinations
// - Multicast copies each word to every receiver
// - Blocking path: full sender when receiver stalls
// - 16-bit items packed, first in low half
// - Block flag means 64-word burst possible
module vfrs_switch
    import vfrs_pkg::*;
#(
    parameter int NODES = `VFRS_NODES,
    parameter int DEPTH = `VFRS_FIFO_DEPTH
)(
    input  wire logic                   i_mclk,
    input  wire logic                   i_rst,
    input  wire logic                   i_ce,
    input  wire logic                   i_run,
    input  wire logic                   i_cfg_we,
    input  wire logic [2:0]             i_cfg_slot,
    input  wire logic                   i_cfg_valid,
    input  wire logic [2:0]             i_cfg_src,
    input  wire logic [NODES-1:0]       i_cfg_dst,
    input  wire logic [NODES-1:0]       i_half_mode,
    input  wire logic [NODES-1:0]       i_sock_clk,
    input  wire logic [NODES-1:0]       i_sock_wen,
    input  wire logic [NODES*32-1:0]    i_sock_wdata,
    input  wire logic [NODES-1:0]       i_sock_ren,
    output logic      [NODES*32-1:0]    o_sock_rdata,
    output logic      [NODES-1:0]       o_sock_full,
    output logic      [NODES-1:0]       o_sock_empty,
    output logic      [NODES-1:0]       o_sock_blk_wr,
    output logic      [NODES-1:0]       o_sock_blk_rd,
    output logic      [NODES-1:0]       o_connected,
    output logic      [2:0]             o_ring_slot
);
    localparam int SLOTS = `VFRS_FRAME_SLOTS;
    if (NODES != `VFRS_NODES)
    begin : g_bad_nodes
        $error("vfrs_switch: node count is fixed at six");
    end

    // Slot table, written only outside the run phase
    logic             slot_valid [SLOTS];
    logic [2:0]       slot_src   [SLOTS];
    logic [NODES-1:0] slot_dst   [SLOTS];
    logic [2:0]       slot;

    // Pin synchronisers
    logic [NODES-1:0]    clk_s1, clk_s2, clk_s3;
    logic [NODES-1:0]    wen_s1, wen_s2, ren_s1, ren_s2;
    logic [NODES*32-1:0] wd_s1, wd_s2;
    logic [NODES-1:0]    half_s1, half_s2;

    // Which nodes act as a source or destination in any slot
    function automatic logic [NODES-1:0] src_mask();
        logic [NODES-1:0] m;
        m = '0;
        for (int s = 0; s < SLOTS; s++)
            if (slot_valid[s])
                m[slot_src[s]] = 1'b1;
        return m;
    endfunction

    function automatic logic [NODES-1:0] dst_mask();
        logic [NODES-1:0] m;
        m = '0;
        for (int s = 0; s < SLOTS; s++)
            if (slot_valid[s])
                m = m | slot_dst[s];
        return m;
    endfunction

    wire [NODES-1:0] has_src  = src_mask();
    wire [NODES-1:0] has_dst  = dst_mask();
    wire [NODES-1:0] sock_edge = clk_s2 & ~clk_s3;

    // FIFO signals per node
    logic [NODES-1:0]    of_wr, of_rd, of_full, of_empty, of_blkw;
    logic [NODES-1:0]    if_wr, if_rd, if_full, if_empty, if_blkr;
    logic [NODES*32-1:0] of_wdata, of_rdata, if_rdata;

    // Ring slot transfer: all receivers must have room so every copy lands
    wire             cur_valid = slot_valid[slot] && i_run;
    wire [2:0]       cur_src   = slot_src[slot];
    wire [NODES-1:0] cur_dst   = slot_dst[slot];
    wire             dst_ready = ((if_full & cur_dst) == '0) && (cur_dst != '0);
    wire             ring_move = cur_valid && !of_empty[cur_src] && dst_ready;
    wire [31:0]      ring_word = of_rdata[cur_src*32 +: 32];

    // 16-bit packing state per node
    logic [NODES-1:0]  pk_have;
    logic [NODES*16-1:0] pk_low;
    logic [NODES-1:0]  up_high;

    genvar n;
    generate
        for (n = 0; n < NODES; n++)
        begin : g_node
            wire        half  = half_s2[n];
            wire        wr_ev = sock_edge[n] && wen_s2[n] && has_src[n];
            wire [31:0] wd    = wd_s2[n*32 +: 32];
            assign of_wr[n]    = wr_ev && (!half || pk_have[n]);
            assign of_wdata[n*32 +: 32] = half ? {wd[15:0], pk_low[n*16 +: 16]} : wd;
            assign of_rd[n]    = ring_move && (cur_src == 3'(n));
            assign if_wr[n]    = ring_move && cur_dst[n];
            assign if_rd[n]    = sock_edge[n] && ren_s2[n] && has_dst[n] && (!half || up_high[n]);

            // Output FIFO: socket fills, ring drains
            vfrs_fifo #(.WIDTH(32), .DEPTH(DEPTH), .BLOCK(`VFRS_BLOCK_WORDS)) u_out (
                .i_mclk   (i_mclk),
                .i_rst    (i_rst),
                .i_ce     (i_ce),
                .i_flush  (!i_run),
                .i_wr     (of_wr[n]),
                .i_wdata  (of_wdata[n*32 +: 32]),
                .i_rd     (of_rd[n]),
                .o_rdata  (of_rdata[n*32 +: 32]),
                .o_full   (of_full[n]),
                .o_empty  (of_empty[n]),
                .o_blk_wr (of_blkw[n]),
                .o_blk_rd ()
            );
            // Input FIFO: ring fills, socket drains
            vfrs_fifo #(.WIDTH(32), .DEPTH(DEPTH), .BLOCK(`VFRS_BLOCK_WORDS)) u_in (
                .i_mclk   (i_mclk),
                .i_rst    (i_rst),
                .i_ce     (i_ce),
                .i_flush  (!i_run),
                .i_wr     (if_wr[n]),
                .i_wdata  (ring_word),
                .i_rd     (if_rd[n]),
                .o_rdata  (if_rdata[n*32 +: 32]),
                .o_full   (if_full[n]),
                .o_empty  (if_empty[n]),
                .o_blk_wr (),
                .o_blk_rd (if_blkr[n])
            );
            always_ff @(posedge i_mclk)
            begin
                if (i_rst || (i_ce && !half_s2[n]))
                begin
                    pk_have[n] <= 1'b0;
                    up_high[n] <= 1'b0;
                    pk_low[n*16 +: 16] <= 16'h0000;
                end
                else if (i_ce)
                begin
                    if (wr_ev && !of_full[n])
                    begin
                        pk_have[n] <= !pk_have[n];
                        if (!pk_have[n])
                            pk_low[n*16 +: 16] <= wd[15:0];
                    end
                    if (sock_edge[n] && ren_s2[n] && has_dst[n] && !if_empty[n])
                        up_high[n] <= !up_high[n];
                end
            end

            // Socket-facing flags and data, registered
            always_ff @(posedge i_mclk)
            begin
                if (i_rst)
                begin
                    o_sock_full[n]   <= 1'b1;
                    o_sock_empty[n]  <= 1'b1;
                    o_sock_blk_wr[n] <= 1'b0;
                    o_sock_blk_rd[n] <= 1'b0;
                    o_sock_rdata[n*32 +: 32] <= 32'h0000_0000;
                end
                else if (i_ce)
                begin
                    o_sock_full[n]   <= of_full[n] || !has_src[n] || !i_run;
                    o_sock_empty[n]  <= if_empty[n] || !has_dst[n] || !i_run;
                    o_sock_blk_wr[n] <= of_blkw[n] && has_src[n] && i_run && !half;
                    o_sock_blk_rd[n] <= if_blkr[n] && has_dst[n] && i_run && !half;
                    o_sock_rdata[n*32 +: 32] <= (half && up_high[n])
                        ? {16'h0000, if_rdata[n*32+16 +: 16]}
                        : (half ? {16'h0000, if_rdata[n*32 +: 16]} : if_rdata[n*32 +: 32]);
                end
            end
        end
    endgenerate

    // Synchronisers for socket pins and half mode, including socket clocks
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            clk_s1 <= '0; clk_s2 <= '0; clk_s3 <= '0;
            wen_s1 <= '0; wen_s2 <= '0; ren_s1 <= '0; ren_s2 <= '0;
            wd_s1  <= '0; wd_s2  <= '0; half_s1 <= '0; half_s2 <= '0;
        end
        else if (i_ce)
        begin
            clk_s1  <= i_sock_clk;   clk_s2  <= clk_s1;  clk_s3 <= clk_s2;
            wen_s1  <= i_sock_wen;   wen_s2  <= wen_s1;
            ren_s1  <= i_sock_ren;   ren_s2  <= ren_s1;
            wd_s1   <= i_sock_wdata; wd_s2   <= wd_s1;
            half_s1 <= i_half_mode;  half_s2 <= half_s1;
        end
    end

    // Ring slot counter and configuration table
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            slot <= 3'h0;
            for (int s = 0; s < SLOTS; s++)
            begin
                slot_valid[s] <= 1'b0;
                slot_src[s]   <= 3'h0;
                slot_dst[s]   <= '0;
            end
        end
        else if (i_ce)
        begin
            slot <= (slot == 3'(SLOTS-1)) ? 3'h0 : slot + 3'h1;
            if (i_cfg_we && !i_run && i_cfg_slot < 3'(SLOTS))
            begin
                slot_valid[i_cfg_slot] <= i_cfg_valid && i_cfg_src < 3'(NODES);
                slot_src[i_cfg_slot]   <= i_cfg_src;
                slot_dst[i_cfg_slot]   <= i_cfg_dst;
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            o_connected <= '0;
            o_ring_slot <= 3'h0;
        end
        else if (i_ce)
        begin
            o_connected <= has_src | has_dst;
            o_ring_slot <= slot;
        end
    end
endmodule

// ===== dv/vfrs_switch_props.sv
/* Port assertions for the ring switch.
   Assumes a bind onto vfrs_switch and one clock domain. */
`timescale 1ns/10ps
module vfrs_switch_props
    import vfrs_pkg::*;
#(
    parameter int NODES = 6
)(
    input logic             i_mclk,
    input logic             i_rst,
    input logic             i_ce,
    input logic             i_run,
    input logic [NODES-1:0] o_sock_full,
    input logic [NODES-1:0] o_sock_empty,
    input logic [NODES-1:0] o_sock_blk_rd,
    input logic [NODES-1:0] o_connected,
    input logic [2:0]       o_ring_slot
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    rst_flags_a: assert property (disable iff (1'b0) i_rst && i_ce |=> &o_sock_full && &o_sock_empty)
        else $error("flags open after reset");
    idle_full_a: assert property (i_ce && !i_run |=> &o_sock_full)
        else $error("sender open outside run");
    idle_empty_a: assert property (i_ce && !i_run |=> &o_sock_empty)
        else $error("receiver open outside run");
    unconn_shut_a: assert property (((o_sock_full & o_sock_empty) | o_connected) == '1)
        else $error("unconnected node open");
    blk_empty_a: assert property ((o_sock_blk_rd & o_sock_empty) == '0)
        else $error("block flag while empty");
    cfg_hold_a: assert property (i_run [*3] |-> $stable(o_connected))
        else $error("table changed in run");
    ring_step_a: assert property (i_ce [*7] |=> o_ring_slot == $past(o_ring_slot, 6))
        else $error("ring period not six");
    slot_range_a: assert property (o_ring_slot <= 3'h5)
        else $error("ring slot out of range");
    cover property (i_run && $fell(o_sock_empty[2]));
    cover property (i_run && $rose(o_sock_full[1]));
    cover property (o_sock_blk_rd[2]);
endmodule

bind vfrs_switch vfrs_switch_props #(.NODES(NODES)) u_props (.*);

// ===== dv/vfrs_sock_model.sv
/* Socket modules at all six sites, one framed transfer at a time.
   Assumes the bench calls put and get in turn. */
`timescale 1ns/10ps
module vfrs_sock_model
    import vfrs_pkg::*;
(
    input  logic         i_mclk,
    input  logic [5:0]   i_full,
    input  logic [5:0]   i_empty,
    input  logic [191:0] i_rdata,
    output logic [5:0]   o_clk = '0,
    output logic [5:0]   o_wen = '0,
    output logic [191:0] o_wdata = '0,
    output logic [5:0]   o_ren = '0,
    output logic         o_got = 1'b0,
    output logic [2:0]   o_got_node = '0,
    output vfrs_word_t   o_got_data = '0
);
    // One 400 ns clock per word; clock stands low between frames
    task automatic frame(input int n);
        repeat (4) @(posedge i_mclk);
        o_clk[n] <= 1'b1;
        o_got <= o_ren[n];
        o_got_node <= 3'(n);
        o_got_data <= i_rdata[n*32+:32];
        @(posedge i_mclk);
        o_got <= 1'b0;
        repeat (3) @(posedge i_mclk);
        o_clk[n] <= 1'b0;
    endtask
    task automatic put(input int n, input vfrs_word_t d, output bit ok);
        @(posedge i_mclk);
        ok = !i_full[n];
        o_wen[n] <= ok;
        o_wdata[n*32+:32] <= d;
        frame(n);
        o_wen[n] <= 1'b0;
        o_wdata[n*32+:32] <= ~d;
    endtask
    task automatic get(input int n, output bit ok);
        @(posedge i_mclk);
        ok = !i_empty[n];
        o_ren[n] <= ok;
        frame(n);
        o_ren[n] <= 1'b0;
    endtask
endmodule

// ===== dv/tb_vfrs_switch.sv
/* Self-checking bench for the ring switch.
   Assumes the socket model drives every socket pin. */
`timescale 1ns/10ps
module tb_vfrs_switch
    import vfrs_pkg::*;
;
    logic         i_mclk = 1'b0;
    logic         i_rst = 1'b1;
    logic         i_ce = 1'b1;
    logic         i_run = 1'b0;
    logic         i_cfg_we = 1'b0;
    logic         i_cfg_valid = 1'b1;
    logic [2:0]   i_cfg_slot = '0;
    logic [2:0]   i_cfg_src = '0;
    logic [5:0]   i_cfg_dst = '0;
    logic [5:0]   i_half_mode = '0;
    logic [5:0]   i_sock_clk, i_sock_wen, i_sock_ren, o_sock_full, o_sock_empty;
    logic [5:0]   o_sock_blk_wr, o_sock_blk_rd, o_connected;
    logic [191:0] i_sock_wdata, o_sock_rdata;
    logic [2:0]   o_ring_slot, got_node;
    logic         got;
    vfrs_word_t   got_data, a, b;
    vfrs_word_t   exp_q[6][$];
    logic [31:0]  seed = 32'hb19f9190;
    int           mismatches = 0;
    int           tests_run = 0;
    int           cycles = 0;
    int           n;
    bit           ok;

    vfrs_switch dut (.*);
    vfrs_sock_model m (.i_mclk(i_mclk), .i_full(o_sock_full), .i_empty(o_sock_empty), .i_rdata(o_sock_rdata),
        .o_clk(i_sock_clk), .o_wen(i_sock_wen), .o_wdata(i_sock_wdata), .o_ren(i_sock_ren), .o_got(got),
        .o_got_node(got_node), .o_got_data(got_data));

    always #25 i_mclk = ~i_mclk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            $display("Error at %0t got %h expected %h", $time, g, e);
            mismatches++;
        end
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic cfg(input int s, input int src, input logic [5:0] dst);
        i_cfg_we <= 1'b1;
        i_cfg_slot <= 3'(s);
        i_cfg_src <= 3'(src);
        i_cfg_dst <= dst;
        @(posedge i_mclk);
    endtask

    // Watcher: every word read at a socket is matched with the oldest note
    always @(posedge i_mclk)
    begin
        cycles++;
        if (got === 1'b1)
            chk(got_data, exp_q[got_node].size() ? exp_q[got_node].pop_front() : ~got_data);
        if (cycles == 20000)
        begin
            mismatches++;
            close_out();
        end
    end

    initial
    begin
        repeat (16) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        chk({o_sock_full, o_sock_empty, o_connected}, 32'h3ffc0);
        i_half_mode <= 6'h08;
        cfg(0, 1, 6'h04);
        cfg(1, 1, 6'h04);
        cfg(2, 0, 6'h14);
        cfg(3, 3, 6'h10);
        // Slot beyond the ring and a bad source must leave node 5 unused
        cfg(6, 5, 6'h20);
        cfg(4, 6, 6'h20);
        i_cfg_valid <= 1'b0;
        cfg(5, 5, 6'h20);
        i_cfg_valid <= 1'b1;
        i_run <= 1'b1;
        cfg(5, 5, 6'h20);
        i_cfg_we <= 1'b0;
        repeat (4) @(posedge i_mclk);
        chk(o_connected, 6'h1f);
        $display("config test done");
        for (n = 0; n < 6; n++)
        begin
            a = rnd();
            m.put(n < 3, a, ok);
            exp_q[2].push_back(a);
            if (n > 2)
                exp_q[4].push_back(a);
        end
        repeat (6) m.get(2, ok);
        repeat (3) m.get(4, ok);
        chk(exp_q[2].size() + exp_q[4].size(), 0);
        $display("stream test done");
        n = 0;
        ok = 1'b1;
        while (ok && n < 400)
        begin
            a = rnd();
            m.put(1, a, ok);
            if (ok)
                exp_q[2].push_back(a);
            n += ok;
        end
        chk({o_sock_full[1], o_sock_blk_rd[2]}, 2'b11);
        repeat (n) m.get(2, ok);
        repeat (2) @(posedge i_mclk);
        chk({exp_q[2].size() == 0, o_sock_empty[2], o_sock_blk_rd[2], o_sock_blk_wr[1]}, 4'b1101);
        $display("blocking test done");
        a = rnd();
        b = rnd();
        m.put(3, a, ok);
        m.put(3, b, ok);
        exp_q[4].push_back({b[15:0], a[15:0]});
        repeat (16) @(posedge i_mclk);
        m.get(4, ok);
        chk(exp_q[4].size(), 0);
        // Node 4 turns 16-bit: each word leaves as low item, then high item
        i_half_mode <= 6'h18;
        a = rnd();
        m.put(0, a, ok);
        exp_q[2].push_back(a);
        exp_q[4].push_back({16'h0000, a[15:0]});
        exp_q[4].push_back({16'h0000, a[31:16]});
        repeat (16) @(posedge i_mclk);
        m.get(2, ok);
        repeat (2) m.get(4, ok);
        chk(exp_q[2].size() + exp_q[4].size(), 0);
        $display("packing test done");
        i_ce <= 1'b0;
        @(posedge i_mclk);
        b = 32'(o_ring_slot);
        repeat (4) @(posedge i_mclk);
        chk(o_ring_slot, b);
        i_ce <= 1'b1;
        repeat (2) @(posedge i_mclk);
        b = 32'(o_ring_slot);
        @(posedge i_mclk);
        chk(o_ring_slot, (b + 32'h1) % 32'h6);
        $display("enable test done");
        i_run <= 1'b0;
        repeat (3) @(posedge i_mclk);
        chk({o_sock_full, o_sock_empty}, 12'hfff);
        $display("phase test done");
        close_out();
    end
endmodule
